/* File: logic/acf_regs.sv */
// Accelerometer FIFO port, level, identity, power and offset registers
//
// Overview of operation
// R1: Power control bit 7 keeps FIFO filling in low-power mode; resets 0.
// R2: Power control bits 5,4,3 put X,Y,Z axis in standby when set.
// R3: FIFO level is a 13-bit byte count split over high/low registers.
// R4: Reading the high level byte snapshots the whole count for both bytes.
// R5: Host reads high level byte before low byte to get a fresh count.
// R6: Data port read pops one byte, write pushes one byte.
// R7: Sample bytes enter the FIFO in ascending sensor register order.
// R8: A sensor register's bytes enter only when its source enable is set.
// R9: Overflow sets a sticky overrun flag.
// R10: Overflow drops oldest bytes unless stop-when-full is set.
// R11: Reading the data port while empty returns 0xff.
// R12: Stored data bytes never take the value 0xff.
// R13: Identity register returns a fixed 8-bit code.
// R14: Bus address is 0x68 or 0x69 per the address select pin.
// R15: Offsets are 15 bits: high byte holds 14:7, low bits 7:1 hold 6:0.
// R16: Offset subtracts from axis output in fixed 16g-span steps.
// R17: Low-power mode is cycle set with sleep and standby clear.
// R18: FIFO reset empties the FIFO in one cycle.
// R19: 512-byte FIFO, oldest first; count tracks pushes and pops.
`include "acf_regs_defs.svh"

module acf_regs
  import acf_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5a // Arbitrary identity code
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic [6:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire logic                addr_select_pin,
  output logic      [6:0]          i2c_address,
  input  wire logic                cycle_bit,
  input  wire logic                sleep_bit,
  input  wire logic                standby_bit,
  output logic                     lowpower_mode,
  output logic                     x_axis_standby,
  output logic                     y_axis_standby,
  output logic                     z_axis_standby,
  input  wire logic [13:0]         fifo_src_enable,
  input  wire logic                stop_when_full,
  input  wire logic                fifo_reset_req,
  output logic                     fifo_overrun_flag,
  input  wire logic                overrun_clear,
  input  wire logic [1:0]          full_scale_sel,
  input  wire logic [2:0][15:0]    axis_raw,
  output logic      [2:0][15:0]    axis_corrected,
  input  wire logic                link_clk,
  input  wire logic                smp_valid,
  input  wire acf_smp_t            smp_byte,
  output logic                     smp_ready
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]       pwr2_r;
  logic [2:0][7:0]  ofs_high_r;
  logic [2:0][7:0]  ofs_low_r;
  logic [7:0]       fifo_mem [`ACF_FIFO_DEPTH];
  logic [8:0]       wr_ptr_r;
  logic [8:0]       rd_ptr_r;
  logic [12:0]      count_r;
  logic [12:0]      count_snap_r;
  logic             ad_s1_r;
  logic             ad_s2_r;
  logic             lrst_s1_r;
  logic             lrst_r;
  acf_lk_state_t    lk_state_r;
  acf_smp_t         lk_hold_r;
  logic             req_tgl_r;
  logic             ack_s1_r;
  logic             ack_s2_r;
  logic             req_s1_r;
  logic             req_s2_r;
  logic             ack_tgl_r;
  logic [5:0]       settle_r;
  acf_smp_t         buf_r [2];
  logic             buf_wp_r;
  logic             buf_rp_r;
  logic [1:0]       buf_cnt_r;
  logic             buf_in_ready;
  logic             buf_take;
  logic             buf_valid;
  logic             buf_pop;
  acf_smp_t         buf_head;
  logic [6:0]       src_idx;
  logic             src_keep;
  logic             fifo_active;
  logic             host_push;
  logic             stream_push;
  logic             push_req;
  logic [7:0]       push_data;
  logic             fifo_full;
  logic             fifo_empty;
  logic             do_pop;
  logic             do_push;
  logic             drop_old;
  logic             overflow_evt;
  logic             rd_port;
  logic             rd_high;

  // ****************************************************************
  // Pin synchroniser and bus address
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ad_s1_r     <= 1'b0;
      ad_s2_r     <= 1'b0;
      i2c_address <= `ACF_I2C_BASE;
    end else begin
      ad_s1_r     <= addr_select_pin;
      ad_s2_r     <= ad_s1_r;
      i2c_address <= `ACF_I2C_BASE | {6'h00, ad_s2_r}; // R14
    end
  end

  // ****************************************************************
  // Link side: one byte at a time across by toggle handshake
  // ****************************************************************
  always_ff @(posedge link_clk) begin
    lrst_s1_r <= reset;
    lrst_r    <= lrst_s1_r;
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      lk_state_r <= ACF_LK_IDLE;
      lk_hold_r  <= '0;
      req_tgl_r  <= 1'b0;
    end else begin
      case (lk_state_r)
        ACF_LK_IDLE: begin
          if (smp_valid) begin
            lk_hold_r  <= smp_byte;
            req_tgl_r  <= ~req_tgl_r;
            lk_state_r <= ACF_LK_WAIT;
          end
        end
        ACF_LK_WAIT: begin
          if (ack_s2_r == req_tgl_r) begin
            lk_state_r <= ACF_LK_IDLE;
          end
        end
        default: lk_state_r <= ACF_LK_IDLE;
      endcase
    end
  end

  assign smp_ready = (lk_state_r == ACF_LK_IDLE) && !lrst_r;

  // ****************************************************************
  // Core side: take byte into the two-entry buffer
  // ****************************************************************
  // Link state is unknown until its reset copy has settled; ignore it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settle_r <= `ACF_LINK_SETTLE;
    end else if (settle_r != 6'h00) begin
      settle_r <= settle_r - 6'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || (settle_r != 6'h00)) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
    end
  end

  assign buf_in_ready = (buf_cnt_r != 2'd2);
  assign buf_take     = (req_s2_r != ack_tgl_r) && buf_in_ready;
  assign buf_valid    = (buf_cnt_r != 2'd0);
  assign buf_head     = buf_r[buf_rp_r];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_tgl_r <= 1'b0;
    end else if (buf_take) begin
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || fifo_reset_req) begin
      buf_wp_r  <= 1'b0;
      buf_rp_r  <= 1'b0;
      buf_cnt_r <= 2'd0;
    end else begin
      if (buf_take) begin
        buf_r[buf_wp_r] <= lk_hold_r;
        buf_wp_r        <= ~buf_wp_r;
      end
      if (buf_pop) begin
        buf_rp_r <= ~buf_rp_r;
      end
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_take} - {1'b0, buf_pop};
    end
  end

  // ****************************************************************
  // Source selection and FIFO push/pop
  // ****************************************************************
  assign lowpower_mode = cycle_bit && !sleep_bit && !standby_bit; // R17
  assign fifo_active   = !lowpower_mode || pwr2_r[`ACF_POS_LP_EN]; // R1
  assign src_idx       = buf_head.reg_num - `ACF_FIRST_SENSOR;
  assign src_keep      = (src_idx < 7'(`ACF_SENSOR_REGS))
                         && fifo_src_enable[src_idx[3:0]] // R8
                         && fifo_active;

  assign host_push   = reg_wr && (reg_addr == `ACF_OFS_PORT); // R6
  assign stream_push = buf_valid && src_keep && !host_push;   // R7
  assign push_req    = host_push || stream_push;
  assign push_data   = host_push ? reg_wdata : buf_head.data;
  assign rd_port     = reg_rd && (reg_addr == `ACF_OFS_PORT);
  assign rd_high     = reg_rd && (reg_addr == `ACF_OFS_LVL_HIGH);
  assign fifo_full   = (count_r == 13'(`ACF_FIFO_DEPTH));
  assign fifo_empty  = (count_r == 13'h0000);

  assign do_pop       = rd_port && !fifo_empty;                      // R6
  assign do_push      = push_req
                        && (!fifo_full || do_pop || !stop_when_full); // R10
  assign drop_old     = do_push && fifo_full && !do_pop;              // R10
  assign overflow_evt = push_req && fifo_full && !do_pop;
  assign buf_pop      = buf_valid
                        && (!src_keep || (stream_push && do_push));

  always_ff @(posedge core_clk) begin
    if (do_push) begin
      fifo_mem[wr_ptr_r] <= (push_data == `ACF_EMPTY_MARK)
                            ? `ACF_SUBST_MARK : push_data; // R12
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || fifo_reset_req) begin // R18
      wr_ptr_r <= 9'h000;
      rd_ptr_r <= 9'h000;
      count_r  <= 13'h0000;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 9'h001;
      end
      if (do_pop || drop_old) begin
        rd_ptr_r <= rd_ptr_r + 9'h001; // R19
      end
      count_r <= count_r + {12'h000, do_push}
                 - {12'h000, do_pop || drop_old}; // R19
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fifo_overrun_flag <= 1'b0;
    end else begin
      fifo_overrun_flag <= overflow_evt
                           || (fifo_overrun_flag && !overrun_clear); // R9
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr2_r     <= `ACF_PWR2_RESET;
      ofs_high_r <= {3{`ACF_OFS_RESET}};
      ofs_low_r  <= {3{`ACF_OFS_RESET}};
    end else if (reg_wr) begin
      if (reg_addr == `ACF_OFS_PWR2) begin
        pwr2_r <= reg_wdata & 8'hb8; // R1 R2
      end else if (reg_addr == `ACF_OFS_XOFS_HIGH) begin
        ofs_high_r[0] <= reg_wdata;
      end else if (reg_addr == `ACF_OFS_XOFS_LOW) begin
        ofs_low_r[0] <= reg_wdata & 8'hfe; // R15
      end else if (reg_addr == `ACF_OFS_YOFS_HIGH) begin
        ofs_high_r[1] <= reg_wdata;
      end else if (reg_addr == `ACF_OFS_YOFS_LOW) begin
        ofs_low_r[1] <= reg_wdata & 8'hfe; // R15
      end else if (reg_addr == `ACF_OFS_ZOFS_HIGH) begin
        ofs_high_r[2] <= reg_wdata;
      end else if (reg_addr == `ACF_OFS_ZOFS_LOW) begin
        ofs_low_r[2] <= reg_wdata & 8'hfe; // R15
      end
    end
  end

  assign x_axis_standby = pwr2_r[`ACF_POS_STBY_X]; // R2
  assign y_axis_standby = pwr2_r[`ACF_POS_STBY_Y]; // R2
  assign z_axis_standby = pwr2_r[`ACF_POS_STBY_Z]; // R2

  // ****************************************************************
  // Register reads, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_snap_r <= 13'h0000;
    end else if (rd_high) begin
      count_snap_r <= count_r; // R4
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `ACF_OFS_PWR2) begin
        reg_rdata <= pwr2_r;
      end else if (reg_addr == `ACF_OFS_LVL_HIGH) begin
        reg_rdata <= {3'h0, count_r[12:8]}; // R3 R4
      end else if (reg_addr == `ACF_OFS_LVL_LOW) begin
        reg_rdata <= count_snap_r[7:0]; // R5
      end else if (reg_addr == `ACF_OFS_PORT) begin
        reg_rdata <= fifo_empty ? `ACF_EMPTY_MARK
                                : fifo_mem[rd_ptr_r]; // R11
      end else if (reg_addr == `ACF_OFS_IDENT) begin
        reg_rdata <= IDENTITY_VALUE; // R13
      end else if (reg_addr == `ACF_OFS_XOFS_HIGH) begin
        reg_rdata <= ofs_high_r[0];
      end else if (reg_addr == `ACF_OFS_XOFS_LOW) begin
        reg_rdata <= ofs_low_r[0];
      end else if (reg_addr == `ACF_OFS_YOFS_HIGH) begin
        reg_rdata <= ofs_high_r[1];
      end else if (reg_addr == `ACF_OFS_YOFS_LOW) begin
        reg_rdata <= ofs_low_r[1];
      end else if (reg_addr == `ACF_OFS_ZOFS_HIGH) begin
        reg_rdata <= ofs_high_r[2];
      end else if (reg_addr == `ACF_OFS_ZOFS_LOW) begin
        reg_rdata <= ofs_low_r[2];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ****************************************************************
  // Offset cancellation per axis
  // ****************************************************************
  // Offset LSB is 1/1024 g; raw LSB is range/32768, so scale by 2^(4-fs)
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [14:0] ofs_val;
    logic signed [19:0] ofs_scaled;
    logic signed [19:0] diff;
    assign ofs_val    = {ofs_high_r[a], ofs_low_r[a][7:1]}; // R15
    assign ofs_scaled = 20'(ofs_val) <<< (3'd4 - {1'b0, full_scale_sel});
    assign diff       = 20'(signed'(axis_raw[a])) - ofs_scaled; // R16
    always_ff @(posedge core_clk) begin
      if (reset) begin
        axis_corrected[a] <= 16'h0000;
      end else if (diff > 20'sh07fff) begin
        axis_corrected[a] <= 16'h7fff;
      end else if (diff < -20'sh08000) begin
        axis_corrected[a] <= 16'h8000;
      end else begin
        axis_corrected[a] <= diff[15:0];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence high_read_s;
    reg_rd && reg_addr == `ACF_OFS_LVL_HIGH && !reset;
  endsequence

  sequence low_read_s;
    reg_rd && reg_addr == `ACF_OFS_LVL_LOW;
  endsequence

  level_snapshot_a: assert property ( // R4
    @(posedge core_clk) disable iff (reset)
    high_read_s |=> count_snap_r == $past(count_r))
    else $error("level snapshot broken");

  low_from_snap_a: assert property ( // R5
    @(posedge core_clk) disable iff (reset)
    high_read_s ##1 !reg_rd ##1 low_read_s
      |=> reg_rdata == $past(count_r[7:0], 3))
    else $error("low level byte not from snapshot");

  high_byte_a: assert property ( // R3
    @(posedge core_clk) disable iff (reset)
    high_read_s |=> reg_rdata == {3'h0, $past(count_r[12:8])})
    else $error("high level byte wrong");

  empty_mark_a: assert property ( // R11
    @(posedge core_clk) disable iff (reset)
    rd_port && fifo_empty |=> reg_rdata == `ACF_EMPTY_MARK)
    else $error("empty port read not 0xff");

  no_ff_data_a: assert property ( // R12
    @(posedge core_clk) disable iff (reset)
    rd_port && !fifo_empty |=> reg_rdata != `ACF_EMPTY_MARK)
    else $error("stored byte reads as 0xff");

  count_step_a: assert property ( // R19
    @(posedge core_clk) disable iff (reset || fifo_reset_req)
    do_push && !do_pop && !fifo_full |=> count_r == $past(count_r) + 13'h1)
    else $error("count did not rise on push");

  count_limit_a: assert property ( // R19
    @(posedge core_clk) disable iff (reset)
    count_r <= 13'(`ACF_FIFO_DEPTH))
    else $error("count above depth");

  stop_full_a: assert property ( // R10
    @(posedge core_clk) disable iff (reset || fifo_reset_req)
    stop_when_full && fifo_full && !rd_port
      |=> count_r == 13'(`ACF_FIFO_DEPTH) && rd_ptr_r == $past(rd_ptr_r))
    else $error("full FIFO overwritten in stop mode");

  overrun_set_a: assert property ( // R9
    @(posedge core_clk) disable iff (reset)
    push_req && fifo_full && !rd_port |=> fifo_overrun_flag)
    else $error("overrun flag not set");

  fifo_clear_a: assert property ( // R18
    @(posedge core_clk) disable iff (reset)
    fifo_reset_req |=> count_r == 13'h0000 && fifo_empty)
    else $error("FIFO reset did not empty");

  src_gate_a: assert property ( // R8
    @(posedge core_clk) disable iff (reset)
    stream_push |-> fifo_src_enable[src_idx[3:0]])
    else $error("disabled source entered FIFO");

  addr_pin_a: assert property ( // R14
    @(posedge core_clk) disable iff (reset)
    addr_select_pin[*4] |-> i2c_address == 7'h69)
    else $error("bus address not 0x69");

endmodule : acf_regs

/* File: logic/acf_regs_defs.svh */
// Register offsets, field positions, reset values and counts of the block
`ifndef ACF_REGS_DEFS_SVH
`define ACF_REGS_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACF_OFS_PWR2      7'h6c
`define ACF_OFS_LVL_HIGH  7'h72
`define ACF_OFS_LVL_LOW   7'h73
`define ACF_OFS_PORT      7'h74
`define ACF_OFS_IDENT     7'h75
`define ACF_OFS_XOFS_HIGH 7'h77
`define ACF_OFS_XOFS_LOW  7'h78
`define ACF_OFS_YOFS_HIGH 7'h7a
`define ACF_OFS_YOFS_LOW  7'h7b
`define ACF_OFS_ZOFS_HIGH 7'h7d
`define ACF_OFS_ZOFS_LOW  7'h7e

// ****************************************************************
// Field positions
// ****************************************************************
`define ACF_POS_LP_EN     7
`define ACF_POS_STBY_X    5
`define ACF_POS_STBY_Y    4
`define ACF_POS_STBY_Z    3

// ****************************************************************
// Values and counts
// ****************************************************************
`define ACF_PWR2_RESET    8'h00
`define ACF_OFS_RESET     8'h00
`define ACF_EMPTY_MARK    8'hff
`define ACF_SUBST_MARK    8'hfe
`define ACF_I2C_BASE      7'h68
`define ACF_FIFO_DEPTH    512
`define ACF_FIRST_SENSOR  7'h3b
`define ACF_SENSOR_REGS   14
`define ACF_LINK_SETTLE   6'h20

`endif

/* File: logic/acf_pkg.sv */
// Types shared by the accelerometer FIFO and offset register block
package acf_pkg;

  typedef struct packed {
    logic [6:0] reg_num;
    logic [7:0] data;
  } acf_smp_t;

  typedef enum logic [0:0] {
    ACF_LK_IDLE = 1'b0,
    ACF_LK_WAIT = 1'b1
  } acf_lk_state_t;

endpackage : acf_pkg

/* File: sim/acf_smp_src.sv */
// Sample byte source model on the link side of the register block
module acf_smp_src
  import acf_pkg::*;
(
  input  wire logic     link_clk,
  input  wire logic     smp_ready,
  output logic          smp_valid,
  output acf_smp_t      smp_byte,
  output logic          src_stuck
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    smp_valid = 1'h0;
    smp_byte  = '0;
    src_stuck = 1'h0;
  end

  // ****************************************************************
  // Offer one byte and hold it until the block takes it
  // ****************************************************************
  task automatic send(input logic [6:0] rn, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge link_clk);
    smp_valid <= 1'h1;
    smp_byte  <= '{reg_num: rn, data: d};
    do begin
      @(negedge link_clk);
      n++;
    end while (smp_ready !== 1'h1 && n < 400);
    if (n >= 400) src_stuck <= 1'h1;
    @(posedge link_clk);
    smp_valid     <= 1'h0;
    // Idle data shows the inverse so a stale byte is never reused
    smp_byte.data <= ~d;
  endtask
endmodule // acf_smp_src

/* File: sim/tb_acf_regs.sv */
// Self-checking bench of the accelerometer FIFO and offset registers
`include "acf_regs_defs.svh"

module tb_acf_regs;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identity code

  logic             core_clk = 1'h0;
  logic             link_clk = 1'h0;
  logic             reset = 1'h1;
  logic [6:0]       reg_addr = '0;
  logic [7:0]       reg_wdata = '0;
  logic             reg_wr = 1'h0;
  logic             reg_rd = 1'h0;
  logic [7:0]       reg_rdata;
  logic             addr_select_pin = 1'h0;
  logic [6:0]       i2c_address;
  logic             cycle_bit = 1'h0;
  logic             sleep_bit = 1'h0;
  logic             standby_bit = 1'h0;
  logic             lowpower_mode;
  logic             x_axis_standby, y_axis_standby, z_axis_standby;
  logic [13:0]      fifo_src_enable = 14'h3fff;
  logic             stop_when_full = 1'h0;
  logic             fifo_reset_req = 1'h0;
  logic             fifo_overrun_flag;
  logic             overrun_clear = 1'h0;
  logic [1:0]       full_scale_sel = 2'h3;
  logic [2:0][15:0] axis_raw = '0;
  logic [2:0][15:0] axis_corrected;
  logic             smp_valid, smp_ready, src_stuck;
  acf_pkg::acf_smp_t smp_byte;
  int               err_total = 0;
  int               checks = 0;

  always #10 core_clk = ~core_clk;
  always #80 link_clk = ~link_clk;

  acf_regs #(.IDENTITY_VALUE(ID_VAL)) acf_regs_i (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .addr_select_pin(addr_select_pin),
    .i2c_address(i2c_address), .cycle_bit(cycle_bit),
    .sleep_bit(sleep_bit), .standby_bit(standby_bit),
    .lowpower_mode(lowpower_mode), .x_axis_standby(x_axis_standby),
    .y_axis_standby(y_axis_standby), .z_axis_standby(z_axis_standby),
    .fifo_src_enable(fifo_src_enable), .stop_when_full(stop_when_full),
    .fifo_reset_req(fifo_reset_req),
    .fifo_overrun_flag(fifo_overrun_flag),
    .overrun_clear(overrun_clear), .full_scale_sel(full_scale_sel),
    .axis_raw(axis_raw), .axis_corrected(axis_corrected),
    .link_clk(link_clk), .smp_valid(smp_valid), .smp_byte(smp_byte),
    .smp_ready(smp_ready));

  acf_smp_src acf_smp_src_i (.link_clk(link_clk), .smp_ready(smp_ready),
    .smp_valid(smp_valid), .smp_byte(smp_byte), .src_stuck(src_stuck));

  // ****************************************************************
  // Compare and register access tasks
  // ****************************************************************
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e,
                       input string nm);
    logic [7:0] v;
    rd(a, v);
    chk8(nm, e, v);
  endtask

  task automatic level(input logic [12:0] e);
    logic [7:0] h;
    logic [7:0] l;
    rd(`ACF_OFS_LVL_HIGH, h);
    rd(`ACF_OFS_LVL_LOW, l);
    chk8("fifo_level_high", {3'h0, e[12:8]}, h);
    chk8("fifo_level_low", e[7:0], l);
  endtask

  task automatic pulse_clear_then_reset;
    @(posedge core_clk);
    overrun_clear <= 1'h1;
    @(posedge core_clk);
    overrun_clear <= 1'h0;
    @(posedge core_clk);
    #1 chk8("fifo_overrun_flag", 8'h00, {7'h0, fifo_overrun_flag});
    fifo_reset_req <= 1'h1;
    @(posedge core_clk);
    fifo_reset_req <= 1'h0;
    level(13'h0000);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rdchk(`ACF_OFS_PWR2, `ACF_PWR2_RESET, "power_control_two");
    rdchk(`ACF_OFS_ZOFS_LOW, `ACF_OFS_RESET, "z_offset_low");
    rdchk(`ACF_OFS_IDENT, ID_VAL, "device_identity");
    rdchk(7'h70, 8'h00, "unmapped");
    chk8("i2c_address", 8'h68, {1'h0, i2c_address});
    addr_select_pin <= 1'h1;
    repeat (6) @(posedge core_clk);
    #1 chk8("i2c_address", 8'h69, {1'h0, i2c_address});
    $display("t_reset done");
  endtask

  task automatic t_power;
    wr(`ACF_OFS_PWR2, 8'hff);
    rdchk(`ACF_OFS_PWR2, 8'hb8, "power_control_two");
    wr(`ACF_OFS_PWR2, 8'h28);
    rdchk(`ACF_OFS_PWR2, 8'h28, "power_control_two");
    chk8("standby", 8'h05,
         {5'h0, x_axis_standby, y_axis_standby, z_axis_standby});
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      {cycle_bit, sleep_bit, standby_bit} <= 3'(i);
      @(posedge core_clk);
      #1 chk8("lowpower_mode", {7'h0, i == 4}, {7'h0, lowpower_mode});
    end
    {cycle_bit, sleep_bit, standby_bit} <= 3'h0;
    wr(`ACF_OFS_PWR2, 8'h00);
    $display("t_power done");
  endtask

  task automatic t_offsets;
    wr(`ACF_OFS_XOFS_LOW, 8'h21);
    wr(`ACF_OFS_YOFS_HIGH, 8'h01);
    rdchk(`ACF_OFS_XOFS_LOW, 8'h20, "x_offset_low");
    rdchk(`ACF_OFS_YOFS_HIGH, 8'h01, "y_offset_high");
    axis_raw <= {16'h1000, 16'h1000, 16'h1000};
    for (int fs = 0; fs < 4; fs++) begin
      @(posedge core_clk);
      full_scale_sel <= 2'(fs);
      repeat (4) @(posedge core_clk);
      #1 chk16("x corrected", 16'h1000 - (16'h0010 << (4 - fs)),
               axis_corrected[0]);
      chk16("y corrected", 16'h1000 - (16'h0080 << (4 - fs)),
            axis_corrected[1]);
      chk16("z corrected", 16'h1000, axis_corrected[2]);
    end
    $display("t_offsets done");
  endtask

  task automatic t_stream;
    logic [7:0] exp_q [4] = '{8'h11, 8'hfe, 8'h44, 8'h66};
    fifo_src_enable <= 14'h3ffb;
    acf_smp_src_i.send(7'h3b, 8'h11);
    acf_smp_src_i.send(7'h3c, 8'hff);
    acf_smp_src_i.send(7'h3d, 8'h33);
    acf_smp_src_i.send(7'h3e, 8'h44);
    acf_smp_src_i.send(7'h50, 8'h55);
    acf_smp_src_i.send(7'h48, 8'h66);
    repeat (20) @(posedge core_clk);
    level(13'h0004);
    foreach (exp_q[i]) rdchk(`ACF_OFS_PORT, exp_q[i], "fifo_port");
    rdchk(`ACF_OFS_PORT, 8'hff, "fifo_port");
    rdchk(`ACF_OFS_PORT, 8'hff, "fifo_port");
    rdchk(`ACF_OFS_LVL_LOW, 8'h04, "fifo_level_low");
    cycle_bit <= 1'h1;
    acf_smp_src_i.send(7'h3b, 8'h77);
    repeat (20) @(posedge core_clk);
    wr(`ACF_OFS_PWR2, 8'h80);
    acf_smp_src_i.send(7'h3b, 8'h78);
    repeat (20) @(posedge core_clk);
    rdchk(`ACF_OFS_PORT, 8'h78, "fifo_port");
    rdchk(`ACF_OFS_PORT, 8'hff, "fifo_port");
    cycle_bit <= 1'h0;
    chk8("source stall", 8'h00, {7'h0, src_stuck});
    $display("t_stream done");
  endtask

  task automatic t_overflow;
    stop_when_full <= 1'h1;
    for (int i = 0; i < 513; i++) wr(`ACF_OFS_PORT, 8'(i % 250));
    level(13'h0200);
    chk8("fifo_overrun_flag", 8'h01, {7'h0, fifo_overrun_flag});
    fork
      acf_smp_src_i.send(7'h3b, 8'h5c);
    join_none
    repeat (60) @(posedge core_clk);
    level(13'h0200);
    rdchk(`ACF_OFS_PORT, 8'h00, "fifo_port");
    wait fork;
    repeat (20) @(posedge core_clk);
    level(13'h0200);
    pulse_clear_then_reset();
    stop_when_full <= 1'h0;
    for (int i = 0; i < 513; i++) wr(`ACF_OFS_PORT, 8'(i % 250));
    level(13'h0200);
    rdchk(`ACF_OFS_PORT, 8'h01, "fifo_port");
    chk8("fifo_overrun_flag", 8'h01, {7'h0, fifo_overrun_flag});
    chk8("source stall", 8'h00, {7'h0, src_stuck});
    $display("t_overflow done");
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    t_reset();
    t_power();
    t_offsets();
    t_stream();
    t_overflow();
    stop_test();
  end
endmodule // tb_acf_regs
